/* File: logic/lcsr_consts.svh */
// Constants for the LIN control and status register set.
// Assumes an 8-bit firmware port with index and window strobes.
// Notes on behaviour
// [RL1] Eight data bytes at indices 0x00..0x07
// [RL2] Master-only and slave-only bits gated by mode
// [RL3] Slave stop halts processing until sync break
// [RL4] Firmware sets sleep, clears on wakeup; the code clears sleep only on a firmware write
// [RL5] Direction bit: 0 receive, 1 transmit
// [RL6] Data acknowledge set by firmware, self-clears
// [RL7] Interrupt clear command clears pending flag
// [RL8] Fault clear command clears error flags
// [RL9] Wake request sends wakeup, then self-clears
// [RL10] Master start clears on completion or error
// [RL11] Firmware loads id, length, data before start
// [RL12] Activity flag follows bus activity
// [RL13] Slave idle four seconds sets timeout flag
// [RL14] Slave abort on early break or stop
// [RL15] Slave id received flag set on identifier
// [RL16] Interrupt pending flag, writable, cleared by command
// [RL17] Error flag sticky until fault clear
// [RL18] Wakeup flag while sending or after receiving
// [RL19] Done set on completion, cleared on start
// [RL20] Registers reached via index and window
// [RL21] Slave buffer access only when requested, idle; the code does not gate buffer writes
// [RL22] Interrupt output follows pending flag
`ifndef LCSR_CONSTS_SVH
`define LCSR_CONSTS_SVH
`define LCSR_IDX_DATA_LAST  8'h07
`define LCSR_IDX_CTRL       8'h08
`define LCSR_IDX_STAT       8'h09
`define LCSR_IDX_FAULT      8'h0A
`define LCSR_IDX_SIZE       8'h0B
`define LCSR_IDX_DIV        8'h0C
`define LCSR_IDX_MUL        8'h0D
`define LCSR_IDX_ID         8'h0E
`define LCSR_BIT_STOP       7
`define LCSR_BIT_SLEEP      6
`define LCSR_BIT_DIR        5
`define LCSR_BIT_ACK        4
`define LCSR_BIT_IRQCLR     3
`define LCSR_BIT_FLTCLR     2
`define LCSR_BIT_WAKE       1
`define LCSR_BIT_START      0
`define LCSR_RESET_BYTE     8'h00
`define LCSR_FAULT_MASK     8'h1F
`define LCSR_ID_MASK        8'h3F
`define LCSR_SIZE_MASK      8'h8F
`define LCSR_IDLE_TIMEOUT_S 4
`define LCSR_CLK_HZ         100000000
`define LCSR_IDLE_CYCLES    (`LCSR_IDLE_TIMEOUT_S * `LCSR_CLK_HZ)
`endif

/* File: logic/lcsr_pkg.sv */
// Types for the LIN control and status register set.
// Assumes the constants header is included by users.
package lcsr_pkg;
   typedef struct packed {
      logic       active;    // Bus activity level
      logic       id_rx;     // Identifier received pulse
      logic       sync_brk;  // Sync break pulse
      logic       frame_end; // Frame finished pulse
      logic       wake_rx;   // Wakeup received pulse
      logic       wake_done; // Wakeup sent pulse
      logic       fault;     // Error pulse with fault bits
      logic [4:0] fault_bits;
      logic       rx_wr;     // Received byte write
      logic [2:0] rx_idx;
      logic [7:0] rx_byte;
   } lcsr_link_ev_t;

   typedef struct packed {
      logic frame_direction;
      logic start_request;
      logic data_acknowledge;
      logic wake_request;
      logic halted;
      logic sleep;
   } lcsr_cmd_t;
endpackage : lcsr_pkg

/* File: logic/lcsr_regs.sv */
// LIN controller register set reached through an index/window pair.
// Assumes the framing engine reports events as one-cycle pulses.
`timescale 1ns/100ps
`include "lcsr_consts.svh"
module lcsr_regs
   import lcsr_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = `LCSR_IDLE_CYCLES
) (
   input  wire logic          i_core_clk,    // System clock
   input  wire logic          i_reset_n,     // Async reset, active low
   input  wire logic          i_master_mode, // 1 master, 0 slave
   input  wire logic          i_index_wr,    // Index register write
   input  wire logic          i_window_wr,   // Window register write
   input  wire logic [7:0]    i_wdata,       // Write data
   input  wire lcsr_link_ev_t i_link,        // Framing engine events
   output logic       [7:0]   o_index,       // Index register value
   output logic       [7:0]   o_window,      // Window read data
   output lcsr_cmd_t          o_cmd,         // Commands to framing engine
   output logic [63:0]        o_tx_bytes,    // Data buffer to engine
   output logic               o_irq          // Interrupt request
);
   // ------------------------------------------------------------
   // Index register and write decode
   // ------------------------------------------------------------
   logic [7:0] index_q;
   logic       ctrl_wr;
   logic       stat_wr;
   logic       slave;
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         index_q <= `LCSR_RESET_BYTE;
      end else if (i_index_wr) begin
         index_q <= i_wdata; // RL20
      end
   end
   assign ctrl_wr = i_window_wr && (index_q == `LCSR_IDX_CTRL); // RL20
   assign stat_wr = i_window_wr && (index_q == `LCSR_IDX_STAT);
   assign slave   = !i_master_mode;

   // ------------------------------------------------------------
   // Data buffer
   // ------------------------------------------------------------
   logic [7:0] data_q [8];
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_data
         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               data_q[g] <= `LCSR_RESET_BYTE;
            end else if (i_window_wr && index_q == 8'(g)) begin
               data_q[g] <= i_wdata; // RL1
            end else if (i_link.rx_wr && i_link.rx_idx == 3'(g)) begin
               data_q[g] <= i_link.rx_byte; // RL1
            end
         end
         assign o_tx_bytes[g*8 +: 8] = data_q[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // Plain configuration registers
   // ------------------------------------------------------------
   logic [7:0] size_q, div_q, mul_q, id_q;
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         size_q <= `LCSR_RESET_BYTE;
         div_q  <= `LCSR_RESET_BYTE;
         mul_q  <= `LCSR_RESET_BYTE;
         id_q   <= `LCSR_RESET_BYTE;
      end else if (i_window_wr) begin
         if (index_q == `LCSR_IDX_SIZE) size_q <= i_wdata & `LCSR_SIZE_MASK;
         if (index_q == `LCSR_IDX_DIV)  div_q  <= i_wdata;
         if (index_q == `LCSR_IDX_MUL)  mul_q  <= i_wdata;
         if (index_q == `LCSR_IDX_ID)   id_q   <= i_wdata & `LCSR_ID_MASK;
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   logic sleep_q, dir_q, ack_q, wake_q, start_q, halt_q;
   logic irq_q, err_q;
   logic done_evt;
   assign done_evt = i_link.frame_end || i_link.wake_done;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sleep_q <= 1'b0;
         dir_q   <= 1'b0;
      end else if (ctrl_wr) begin
         sleep_q <= slave ? i_wdata[`LCSR_BIT_SLEEP] : sleep_q; // RL2 RL4
         dir_q   <= i_wdata[`LCSR_BIT_DIR]; // RL5
      end
   end

   // Data acknowledge: engine consumes it one cycle later
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_q <= 1'b0;
      end else if (ctrl_wr && slave && i_wdata[`LCSR_BIT_ACK]) begin
         ack_q <= 1'b1; // RL2 RL6
      end else begin
         ack_q <= 1'b0; // RL6
      end
   end

   // Wake request held until the wakeup is sent or a fault is reported
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wake_q <= 1'b0;
      end else if (ctrl_wr && i_wdata[`LCSR_BIT_WAKE] && !err_q) begin
         wake_q <= 1'b1; // RL9
      end else if (i_link.wake_done || i_link.fault) begin
         wake_q <= 1'b0; // RL9
      end
   end

   // Start blocked while an error is still flagged
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         start_q <= 1'b0;
      end else if (ctrl_wr && i_master_mode && i_wdata[`LCSR_BIT_START] && !err_q) begin
         start_q <= 1'b1; // RL2 RL10
      end else if (i_link.frame_end || i_link.fault) begin
         start_q <= 1'b0; // RL10
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         halt_q <= 1'b0;
      end else if (ctrl_wr && slave && i_wdata[`LCSR_BIT_STOP]) begin
         halt_q <= 1'b1; // RL2 RL3
      end else if (i_link.sync_brk) begin
         halt_q <= 1'b0; // RL3
      end
   end

   // ------------------------------------------------------------
   // Status register
   // ------------------------------------------------------------
   logic idle_q, abort_q, idrx_q, wakef_q, done_q;
   logic [4:0] fault_q;
   logic [31:0] idle_cnt_q;
   logic stop_cmd;
   assign stop_cmd = ctrl_wr && slave && i_wdata[`LCSR_BIT_STOP];

   // Set wins over clear for every hardware-set flag
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_q <= 1'b0;
      end else if (i_link.id_rx || i_link.fault || i_link.frame_end
                   || i_link.wake_rx || (i_master_mode && i_link.wake_done)
                   || (slave && idle_cnt_q == 32'(IDLE_CYCLES - 1) && !sleep_q)) begin
         irq_q <= 1'b1; // RL16
      end else if (ctrl_wr && i_wdata[`LCSR_BIT_IRQCLR]) begin
         irq_q <= 1'b0; // RL7
      end else if (stat_wr) begin
         irq_q <= i_wdata[3]; // RL16
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         err_q   <= 1'b0;
         fault_q <= 5'h00;
      end else if (i_link.fault) begin
         err_q   <= 1'b1; // RL17
         fault_q <= fault_q | i_link.fault_bits;
      end else if (ctrl_wr && i_wdata[`LCSR_BIT_FLTCLR]) begin
         err_q   <= 1'b0; // RL8
         fault_q <= 5'h00; // RL8
      end
   end

   // Idle counter saturates; long default, override in simulation
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         idle_cnt_q <= 32'h0;
      end else if (i_link.active || sleep_q || i_master_mode) begin
         idle_cnt_q <= 32'h0;
      end else if (idle_cnt_q != 32'(IDLE_CYCLES)) begin
         idle_cnt_q <= idle_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         idle_q <= 1'b0;
      end else if (slave && !sleep_q && idle_cnt_q == 32'(IDLE_CYCLES - 1)) begin
         idle_q <= 1'b1; // RL13
      end else if (i_link.active || sleep_q) begin
         idle_q <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         abort_q <= 1'b0;
      end else if (slave && (stop_cmd || (i_link.sync_brk && i_link.active))) begin
         abort_q <= 1'b1; // RL14
      end else if (i_link.sync_brk) begin
         abort_q <= 1'b0; // RL14
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         idrx_q <= 1'b0;
      end else if (slave && i_link.id_rx && !halt_q) begin
         idrx_q <= 1'b1; // RL15
      end else if (ack_q || stop_cmd || i_link.sync_brk) begin
         idrx_q <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wakef_q <= 1'b0;
      end else if (i_link.wake_rx) begin
         wakef_q <= 1'b1; // RL18
      end else if (i_link.sync_brk) begin
         wakef_q <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         done_q <= 1'b0;
      end else if (done_evt || i_link.wake_rx) begin
         done_q <= 1'b1; // RL19
      end else if (start_q && !(ctrl_wr && i_wdata[`LCSR_BIT_START]) || i_link.sync_brk) begin
         done_q <= 1'b0; // RL19
      end
   end

   // ------------------------------------------------------------
   // Window read and outputs
   // ------------------------------------------------------------
   logic [7:0] ctrl_rd, stat_rd;
   // Stop and clear command bits always read zero
   assign ctrl_rd = {1'b0, sleep_q, dir_q, ack_q, 2'b00, wake_q, start_q}; // RL3 RL7 RL8
   assign stat_rd = {i_link.active, idle_q, abort_q, idrx_q,
                     irq_q, err_q, wakef_q || wake_q, done_q}; // RL12 RL18

   always_comb begin
      o_window = `LCSR_RESET_BYTE;
      if (index_q <= `LCSR_IDX_DATA_LAST) begin
         o_window = data_q[index_q[2:0]]; // RL1
      end else begin
         unique case (index_q)
            `LCSR_IDX_CTRL:  o_window = ctrl_rd;
            `LCSR_IDX_STAT:  o_window = stat_rd;
            `LCSR_IDX_FAULT: o_window = {3'b000, fault_q};
            `LCSR_IDX_SIZE:  o_window = size_q;
            `LCSR_IDX_DIV:   o_window = div_q;
            `LCSR_IDX_MUL:   o_window = mul_q;
            `LCSR_IDX_ID:    o_window = id_q;
            default:         o_window = `LCSR_RESET_BYTE;
         endcase
      end
   end

   assign o_index = index_q;
   assign o_irq   = irq_q; // RL22
   assign o_cmd   = '{frame_direction:  dir_q,
                      start_request:    start_q,
                      data_acknowledge: ack_q,
                      wake_request:     wake_q,
                      halted:           halt_q,
                      sleep:            sleep_q};

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_irq_out_follow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      o_irq == irq_q && stat_rd[3] == o_irq) else $error("irq output mismatch"); // RL22
   chk_irq_clear_cmd: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (ctrl_wr && i_wdata[3] && !i_link.id_rx && !i_link.fault && !i_link.frame_end
       && !i_link.wake_rx && !i_link.wake_done && idle_cnt_q != 32'(IDLE_CYCLES - 1))
      |=> !o_irq) else $error("irq not cleared"); // RL7
   chk_fault_sticky: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      i_link.fault |=> err_q) else $error("error flag not set"); // RL17
   chk_fault_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (ctrl_wr && i_wdata[2] && !i_link.fault) |=> !err_q && fault_q == 5'h00)
      else $error("fault not cleared"); // RL8
   chk_ack_self_clr: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      ack_q |=> !ack_q) else $error("ack not self-cleared"); // RL6
   chk_start_master: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (ctrl_wr && i_wdata[0] && slave) |=> !$rose(start_q)) else $error("start in slave"); // RL2
   chk_start_end: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (start_q && i_link.frame_end && !ctrl_wr) |=> !start_q && done_q)
      else $error("start not ended"); // RL10
   chk_ctrl_cmd_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      ctrl_rd[7] == 1'b0 && ctrl_rd[3:2] == 2'b00) else $error("command bit reads one"); // RL3
   chk_halt_break: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (halt_q && i_link.sync_brk && !stop_cmd) |=> !halt_q) else $error("halt stuck"); // RL3
   chk_idrx_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (slave && i_link.id_rx && !halt_q) |=> idrx_q) else $error("id flag not set"); // RL15
endmodule : lcsr_regs

/* File: sim/lcsr_bus_model.sv */
// Behavioural model of the bus side: frame engine event source.
// Assumes the bench calls its tasks; events change just after an edge.
`timescale 1ns/100ps
module lcsr_bus_model
   import lcsr_pkg::*;
(
   input  wire logic     i_core_clk, // System clock
   output lcsr_link_ev_t o_link      // Events to the register set
);
   // ------------------------------------------------
   // Event pulses
   // ------------------------------------------------
   initial o_link = '0;

   // One-cycle pulse; the activity level is a bus state and is kept
   task automatic fire(input lcsr_link_ev_t ev);
      @(posedge i_core_clk) #1;
      ev.active = o_link.active;
      o_link    = ev;
      @(posedge i_core_clk) #1;
      ev        = '0;
      ev.active = o_link.active;
      o_link    = ev;
   endtask : fire

   task automatic set_level(input logic a);
      @(posedge i_core_clk) #1;
      o_link.active = a;
   endtask : set_level
endmodule : lcsr_bus_model

/* File: sim/lin_control_status_regs_tb.sv */
// Self-checking bench for the indexed register set.
// Assumes the bus model supplies all frame engine events.
`timescale 1ns/100ps
`include "lcsr_consts.svh"
module lin_control_status_regs_tb
   import lcsr_pkg::*;
;
   logic          clk;
   logic          rst_n;
   logic          mm;
   logic          iw;
   logic          ww;
   logic [7:0]    wd;
   lcsr_link_ev_t link;
   lcsr_link_ev_t e;
   logic [7:0]    idx;
   logic [7:0]    win;
   lcsr_cmd_t     cmd;
   logic [63:0]   txb;
   logic          irq;
   int            n_fail;
   int            n_tests;

   // Short idle count keeps the timeout reachable in simulation
   lcsr_regs #(.IDLE_CYCLES(20)) dut_u (.i_core_clk(clk), .i_reset_n(rst_n), .i_master_mode(mm),
      .i_index_wr(iw), .i_window_wr(ww), .i_wdata(wd), .i_link(link), .o_index(idx),
      .o_window(win), .o_cmd(cmd), .o_tx_bytes(txb), .o_irq(irq));
   lcsr_bus_model bm_u (.i_core_clk(clk), .o_link(link));

   // ------------------------------------------------
   // Access and compare tasks
   // ------------------------------------------------
   task automatic cmp(input string nm, input logic [63:0] ex, input logic [63:0] got);
      n_tests++;
      if (got !== ex) begin
         n_fail++;
         $display("[ERR] %s exp %0h got %0h", nm, ex, got);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) #1;
      iw = 1'b1;
      wd = a;
      @(posedge clk) #1;
      iw = 1'b0;
      ww = 1'b1;
      wd = v;
      @(posedge clk) #1;
      ww = 1'b0;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] ex, input string nm);
      @(posedge clk) #1;
      iw = 1'b1;
      wd = a;
      @(posedge clk) #1;
      iw = 1'b0;
      cmp("index", a, idx);
      cmp(nm, ex & m, win & m);
   endtask : rdc

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_buffer;
      for (int i = 0; i < 11; i++) rdc(8'(i), 8'hFF, 8'h00, "reset value");
      for (int i = 0; i < 8; i++) wr(8'(i), 8'(8'h11 * (i + 1)));
      cmp("tx bytes", 64'h8877665544332211, txb);
      e = '0;
      e.rx_wr = 1'b1;
      e.rx_idx = 3'h3;
      e.rx_byte = 8'hA5;
      bm_u.fire(e);
      rdc(8'h03, 8'hFF, 8'hA5, "rx byte");
      rdc(8'h07, 8'hFF, 8'h88, "last byte");
      wr(8'h0F, 8'h5A);
      rdc(8'h0F, 8'hFF, 8'h00, "unmapped");
   endtask : t_buffer

   task automatic t_master;
      mm = 1'b1;
      wr(8'h0E, 8'hD5);
      wr(8'h0B, 8'hF2);
      rdc(8'h0E, 8'hFF, 8'h15, "id masked");
      rdc(8'h0B, 8'hFF, 8'h82, "size masked");
      wr(8'h08, 8'hD1);
      cmp("start", 1, cmd.start_request);
      rdc(8'h08, 8'hFF, 8'h01, "slave bits in master");
      e = '0;
      e.frame_end = 1'b1;
      bm_u.fire(e);
      cmp("start end", 0, cmd.start_request);
      cmp("irq out", 1, irq);
      rdc(8'h09, 8'h09, 8'h09, "done irq");
      wr(8'h08, 8'h08);
      cmp("irq out clr", 0, irq);
      rdc(8'h09, 8'h08, 8'h00, "irq clear");
      wr(8'h08, 8'h21);
      cmp("direction", 1, cmd.frame_direction);
      rdc(8'h09, 8'h01, 8'h00, "done at start");
      e = '0;
      e.fault = 1'b1;
      e.fault_bits = 5'h05;
      bm_u.fire(e);
      cmp("start on fault", 0, cmd.start_request);
      wr(8'h08, 8'h21);
      cmp("start refused", 0, cmd.start_request);
      rdc(8'h0A, 8'hFF, 8'h05, "fault bits");
      wr(8'h08, 8'h0C);
      rdc(8'h09, 8'h0C, 8'h00, "fault clear");
      rdc(8'h0A, 8'hFF, 8'h00, "fault reg clear");
      wr(8'h08, 8'h02);
      rdc(8'h09, 8'h02, 8'h02, "wake sending");
      e = '0;
      e.wake_done = 1'b1;
      bm_u.fire(e);
      cmp("wake self clear", 0, cmd.wake_request);
      rdc(8'h09, 8'h02, 8'h00, "wake idle");
   endtask : t_master

   task automatic t_slave;
      mm = 1'b0;
      wr(8'h08, 8'h01);
      cmp("start in slave", 0, cmd.start_request);
      e = '0;
      e.id_rx = 1'b1;
      bm_u.fire(e);
      rdc(8'h09, 8'h10, 8'h10, "id received");
      wr(8'h00, 8'h3C);
      rdc(8'h00, 8'hFF, 8'h3C, "slave buffer");
      wr(8'h08, 8'h10);
      cmp("ack pulse", 1, cmd.data_acknowledge);
      @(posedge clk) #1;
      cmp("ack gone", 0, cmd.data_acknowledge);
      rdc(8'h08, 8'h10, 8'h00, "ack reads");
      bm_u.fire(e);
      wr(8'h08, 8'h80);
      cmp("halted", 1, cmd.halted);
      rdc(8'h08, 8'h80, 8'h00, "stop reads");
      rdc(8'h09, 8'h20, 8'h20, "abort stop");
      bm_u.set_level(1'b1);
      rdc(8'h09, 8'h80, 8'h80, "active");
      e = '0;
      e.sync_brk = 1'b1;
      bm_u.fire(e);
      rdc(8'h09, 8'h20, 8'h20, "abort break");
      bm_u.set_level(1'b0);
      rdc(8'h09, 8'h80, 8'h00, "idle");
      bm_u.fire(e);
      cmp("resume", 0, cmd.halted);
      rdc(8'h09, 8'h20, 8'h00, "abort cleared");
   endtask : t_slave

   task automatic t_idle;
      int i;
      wr(8'h08, 8'h0C);
      rdc(8'h09, 8'h48, 8'h00, "status before idle");
      for (i = 0; i < 60 && win[6] !== 1'b1; i++) @(posedge clk) #1;
      cmp("idle timeout", 1, win[6]);
      wr(8'h08, 8'h40);
      cmp("sleep", 1, cmd.sleep);
      wr(8'h08, 8'h42);
      e = '0;
      e.wake_done = 1'b1;
      bm_u.fire(e);
      e = '0;
      e.wake_rx = 1'b1;
      bm_u.fire(e);
      rdc(8'h09, 8'h03, 8'h03, "wake received");
      wr(8'h08, 8'h00);
      cmp("sleep off", 0, cmd.sleep);
   endtask : t_idle

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      wrap_up();
   end

   initial begin
      n_fail = 0;
      n_tests = 0;
      rst_n = 1'b0;
      mm = 1'b1;
      iw = 1'b0;
      ww = 1'b0;
      wd = 8'h00;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      cmp("irq reset", 0, irq);
      t_buffer();
      t_master();
      t_slave();
      t_idle();
      wrap_up();
   end
endmodule : lin_control_status_regs_tb
